// ---- shared/sos_pkg.sv ----
// shared constants and types for the standby and settle-counter controller
package sos_pkg;

  localparam int SETTLE_NB = 5;   // settle_status_register width
  localparam int CNT_W     = 17;  // stabilisation counter width
  localparam int SEL_W     = 3;   // settle_select_register width
  localparam int RO_W      = 5;   // internal-period counter width

  // main-crystal tick counts per selectable settle time, shortest first
  localparam logic [CNT_W-1:0] SETTLE_CNT [SETTLE_NB] =
    '{17'h00800, 17'h02000, 17'h04000, 17'h08000, 17'h10000};

  localparam logic [SEL_W-1:0] SEL_RST  = 3'h4;  // longest wait after reset
  localparam logic [SEL_W-1:0] SEL_MAX  = 3'h4;  // larger codes act as this
  localparam logic [RO_W-1:0]  RO_WAIT  = 5'h11; // internal-osc periods held
  localparam logic [2:0]       OSC_RST  = 3'h2;  // cpu gated, crystal on, int off

  // register byte offsets
  localparam logic [3:0] OFS_STATUS = 4'h0;
  localparam logic [3:0] OFS_SELECT = 4'h4;
  localparam logic [3:0] OFS_STATE  = 4'h8;
  localparam logic [3:0] OFS_CTRL   = 4'hC;

  // state register bit positions
  localparam int STB_HALT    = 0;
  localparam int STB_STOP    = 1;
  localparam int STB_WAIT    = 2;
  localparam int STB_REFUSED = 3;
  localparam int STB_MAIN_EN = 4;
  localparam int STB_INT_EN  = 5;
  localparam int CTB_INT_OFF = 0;  // control: internal oscillator off

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {CLK_MAIN, CLK_INT, CLK_SUB} sos_clk_src_t;

  typedef struct packed {
    logic cpu_clk_en;
    logic main_osc_en;
    logic int_osc_en;
  } sos_osc_ctl_t;

endpackage

// ---- sim/sos_standby_checker.sv ----
// checker: standby sequencing and register bus handshake properties
`timescale 1ns/1ps
module sos_standby_checker (
  input wire logic                  aclk,
  input wire logic                  aresetn,
  input wire logic                  s_axi_awvalid,
  input wire logic                  s_axi_awready,
  input wire logic                  s_axi_wvalid,
  input wire logic                  s_axi_wready,
  input wire logic [1:0]            s_axi_bresp,
  input wire logic                  s_axi_bvalid,
  input wire logic                  s_axi_bready,
  input wire logic                  s_axi_arvalid,
  input wire logic                  s_axi_arready,
  input wire logic [31:0]           s_axi_rdata,
  input wire logic                  s_axi_rvalid,
  input wire logic                  s_axi_rready,
  input wire sos_pkg::sos_clk_src_t cpu_clk_src,
  input wire logic                  halt_req,
  input wire logic                  stop_req,
  input wire logic                  irq_pending,
  input wire sos_pkg::sos_osc_ctl_t osc_ctl
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // both write channels handed over at one edge
  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  // a stop instruction seen while the cpu is clocked
  sequence stop_in_run;
    stop_req && !halt_req && osc_ctl.cpu_clk_en;
  endsequence

  a_stop_sub_refused: assert property (stop_in_run ##0 (cpu_clk_src == sos_pkg::CLK_SUB)
    |=> osc_ctl.cpu_clk_en && osc_ctl.main_osc_en) else $error("stop on subclock taken");
  a_stop_main_gates: assert property (stop_in_run ##0
    (cpu_clk_src == sos_pkg::CLK_MAIN && !irq_pending)
    |=> !osc_ctl.cpu_clk_en && !osc_ctl.main_osc_en) else $error("main stop not gated");
  a_stop_int_keeps: assert property (stop_in_run ##0
    (cpu_clk_src == sos_pkg::CLK_INT && !irq_pending) |=> !osc_ctl.main_osc_en
    && osc_ctl.int_osc_en == $past(osc_ctl.int_osc_en)) else $error("int stop wrong");
  a_halt_any_src: assert property (halt_req && !stop_req && osc_ctl.cpu_clk_en
    |=> !osc_ctl.cpu_clk_en) else $error("halt not taken");
  a_stop_to_halt: assert property (stop_in_run ##0
    (cpu_clk_src != sos_pkg::CLK_SUB && irq_pending)
    |=> (!osc_ctl.cpu_clk_en && osc_ctl.main_osc_en)[*8]) else $error("no fallback wait");
  a_stop_held: assert property (!osc_ctl.cpu_clk_en && !osc_ctl.main_osc_en && !irq_pending
    && cpu_clk_src == sos_pkg::CLK_MAIN |=> !osc_ctl.cpu_clk_en) else $error("stop left");
  a_write_answer: assert property (wr_taken |-> ##[2:3] s_axi_bvalid)
    else $error("write response missing");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid)
    else $error("read response missing");
  a_bresp_stands: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
  a_rdata_stands: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
endmodule

bind sos_standby_ctrl sos_standby_checker u_sos_standby_checker (
  .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .cpu_clk_src, .halt_req, .stop_req,
  .irq_pending, .osc_ctl
);

// ---- sim/testbench.sv ----
// self-checking bench for the standby and settle-counter controller
`timescale 1ns/1ps
module testbench;
  logic                  aclk = 1'b0;
  logic                  aresetn;
  logic [4:0]            awaddr, araddr;     // one bit wide extra to reach a hole
  logic [31:0]           wdata, rdata, d;
  logic [3:0]            wstrb;
  logic [1:0]            bresp, rresp;
  logic                  awvalid, awready, wvalid, wready, bvalid, bready;
  logic                  arvalid, arready, rvalid, rready;
  logic                  halt_req, stop_req, irq_pending, main_osc_ok, main_tick;
  logic                  int_tick, int_run, osc_on;
  sos_pkg::sos_clk_src_t cpu_clk_src;
  sos_pkg::sos_osc_ctl_t osc_ctl;
  int                    errors = 0;
  int                    checks_done = 0;
  int                    n, p, i;

  always #25 aclk = ~aclk;

  // crystal only reports ok while enabled and released by the scenario
  always @(posedge aclk)
    main_osc_ok <= osc_ctl.main_osc_en & osc_on;
  // internal oscillator: one pulse every other cycle while running
  always @(posedge aclk)
    int_tick <= int_run & ~int_tick;

  sos_standby_ctrl #(.ADDR_W(5)) u_sos_standby_ctrl (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .cpu_clk_src(cpu_clk_src),
    .halt_req(halt_req), .stop_req(stop_req), .irq_pending(irq_pending),
    .main_osc_ok(main_osc_ok), .main_tick(main_tick), .int_tick(int_tick),
    .osc_ctl(osc_ctl)
  );

  task automatic wrap_up();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // a wait that ran out is a mismatch and ends the run
  task automatic hang();
    errors++;
    wrap_up();
  endtask

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      errors++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // cycle count must land near a tick threshold; slack covers pipeline stages
  task automatic cmp_rng(input int k, input int c);
    cmp(32'(k >= c - 3 && k <= c + 6), 32'h1);
  endtask

  // bus write: both channels offered together, each dropped when taken
  task automatic wr(input logic [4:0] a, input logic [31:0] v, input logic [3:0] s);
    int k;
    awaddr <= a;
    wdata <= v;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (k = 0; k < 50; k++)
    begin
      @(posedge aclk);
      if (awready)
        awvalid <= 1'b0;
      if (wready)
        wvalid <= 1'b0;
      if (bvalid)
        break;
    end
    if (k == 50)
      hang();
    bready <= 1'b0;
    cmp(32'(bresp), 32'(sos_pkg::RESP_OKAY));
    @(posedge aclk);
  endtask

  task automatic rd(input logic [4:0] a, input logic [1:0] er, output logic [31:0] v);
    int k;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (k = 0; k < 50; k++)
    begin
      @(posedge aclk);
      if (arready)
        arvalid <= 1'b0;
      if (rvalid)
        break;
    end
    if (k == 50)
      hang();
    v = rdata;
    rready <= 1'b0;
    cmp(32'(rresp), 32'(er));
    @(posedge aclk);
  endtask

  task automatic rd_chk(input logic [4:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] v;
    rd(a, sos_pkg::RESP_OKAY, v);
    cmp(v & m, e);
  endtask

  // one-cycle standby instruction, returns once osc_ctl has answered
  task automatic standby(input logic stop);
    stop_req <= stop;
    halt_req <= ~stop;
    @(posedge aclk);
    stop_req <= 1'b0;
    halt_req <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic wait_run(input int lim, output int k);
    for (k = 0; k < lim; k++)
    begin
      @(posedge aclk);
      if (osc_ctl.cpu_clk_en === 1'b1)
        break;
    end
    if (k == lim)
      hang();
  endtask

  // reset release: registers, hole, and a wait that ignores dead crystal time
  task automatic t_boot();
    rd_chk(5'h04, 32'hFFFFFFFF, 32'(sos_pkg::SEL_RST));
    wr(5'h04, 32'h0, 4'hF);
    wr(5'h04, 32'h3, 4'h0);
    rd_chk(5'h04, 32'hFFFFFFFF, 32'h0);
    wr(5'h00, 32'h1F, 4'hF);
    rd_chk(5'h00, 32'hFFFFFFFF, 32'h0);
    rd(5'h10, sos_pkg::RESP_SLVERR, d);
    cmp(d, 32'h0);
    repeat (200) @(posedge aclk);
    cmp(32'(osc_ctl.cpu_clk_en), 32'h0);
    osc_on <= 1'b1;
    wait_run(3000, n);
    cmp_rng(n, int'(sos_pkg::SETTLE_CNT[0]));
    rd_chk(5'h00, 32'hFFFFFFFF, 32'h10);
  endtask

  task automatic t_stop_main();
    wr(5'h04, 32'h1, 4'hF);
    wr(5'h0C, 32'h1, 4'hF);
    cmp(32'(osc_ctl) & 32'h1, 32'h0);
    standby(1'b1);
    cmp(32'(osc_ctl), 32'h0);
    osc_on <= 1'b0;
    rd_chk(5'h00, 32'hFFFFFFFF, 32'h0);
    rd_chk(5'h08, 32'h3F, 32'h02);
    repeat (50) @(posedge aclk);
    cmp(32'(osc_ctl) & 32'h6, 32'h0);
    irq_pending <= 1'b1;
    repeat (300) @(posedge aclk);
    cmp(32'(osc_ctl) & 32'h6, 32'h2);
    rd_chk(5'h08, 32'h3F, 32'h14);
    osc_on <= 1'b1;
    wait_run(9000, n);
    irq_pending <= 1'b0;
    cmp_rng(n, int'(sos_pkg::SETTLE_CNT[1]));
    rd_chk(5'h00, 32'hFFFFFFFF, 32'h18);
  endtask

  // halt from every clock source, then a refused stop on the subclock
  task automatic t_halt_sub();
    for (i = 0; i < 3; i++)
    begin
      cpu_clk_src <= sos_pkg::sos_clk_src_t'(2'(i));
      @(posedge aclk);
      standby(1'b0);
      cmp(32'(osc_ctl.cpu_clk_en), 32'h0);
      rd_chk(5'h08, 32'h1, 32'h1);
      irq_pending <= 1'b1;
      wait_run(50, n);
      irq_pending <= 1'b0;
      @(posedge aclk);
    end
    standby(1'b1);
    cmp(32'(osc_ctl) & 32'h6, 32'h6);
    rd_chk(5'h08, 32'h8, 32'h8);
  endtask

  task automatic t_stop_int();
    cpu_clk_src <= sos_pkg::CLK_INT;
    wr(5'h0C, 32'h0, 4'hF);
    cmp(32'(osc_ctl), 32'h7);
    standby(1'b1);
    cmp(32'(osc_ctl), 32'h1);
    irq_pending <= 1'b1;
    @(posedge aclk);
    int_run <= 1'b1;
    p = 0;
    for (n = 0; n < 200; n++)
    begin
      @(posedge aclk);
      if (osc_ctl.cpu_clk_en === 1'b1)
        break;
      p += int'(int_tick);
    end
    if (n == 200)
      hang();
    int_run <= 1'b0;
    irq_pending <= 1'b0;
    cmp(32'(p), 32'(sos_pkg::RO_WAIT));
  endtask

  // stop with an interrupt already pending falls back to halt plus wait
  task automatic t_stop_irq();
    cpu_clk_src <= sos_pkg::CLK_MAIN;
    wr(5'h04, 32'h0, 4'hF);
    irq_pending <= 1'b1;
    standby(1'b1);
    cmp(32'(osc_ctl) & 32'h6, 32'h2);
    wait_run(3000, n);
    irq_pending <= 1'b0;
    cmp_rng(n, int'(sos_pkg::SETTLE_CNT[0]));
    rd_chk(5'h00, 32'hFFFFFFFF, 32'h10);
  endtask

  initial
  begin
    aresetn = 1'b0;
    {awaddr, araddr, wdata, wstrb} = '0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    {halt_req, stop_req, irq_pending, main_osc_ok} = '0;
    {int_tick, int_run, osc_on} = '0;
    main_tick = 1'b1; // every cycle stands for one crystal period
    cpu_clk_src = sos_pkg::CLK_MAIN;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_boot();
    t_stop_main();
    t_halt_sub();
    t_stop_int();
    t_stop_irq();
    wrap_up();
  end
endmodule

// ---- src/sos_settle_status.sv ----
// settle status bits and end-of-wait detect for the stabilisation counter
`timescale 1ns/1ps
module sos_settle_status #(
  parameter int NB = sos_pkg::SETTLE_NB
) (
  input  wire logic                          aclk,
  input  wire logic                          aresetn,
  input  wire logic                          clr,
  input  wire logic [sos_pkg::CNT_W-1:0]     count,
  input  wire logic [sos_pkg::SEL_W-1:0]     sel,
  output logic [NB-1:0]                      status,
  output logic                               done
);

  logic [NB-1:0]             stat_r;    // sticky status
  logic [NB-1:0]             stat_nxt;  // next status
  logic [sos_pkg::SEL_W-1:0] sel_c;     // clamped select

  assign sel_c = (sel > sos_pkg::SEL_MAX) ? sos_pkg::SEL_MAX : sel;

  // a threshold only counts while it lies inside the selected period;
  // during a clear the count still holds the last run, so it sets nothing
  always_comb
  begin
    stat_nxt = clr ? '0 : stat_r;
    for (int i = 0; i < NB; i++)
      if (!clr && (count >= sos_pkg::SETTLE_CNT[i]) && (i <= int'(sel_c)))
        stat_nxt[NB-1-i] = 1'b1;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      stat_r <= '0;
    else
      stat_r <= stat_nxt;
  end

  assign status = stat_r;
  assign done   = (count >= sos_pkg::SETTLE_CNT[sel_c]);

endmodule

// ---- src/sos_standby_ctrl.sv ----
// standby controller: halt/stop sequencing, oscillator gating, register slave
`timescale 1ns/1ps
module sos_standby_ctrl #(
  parameter int ADDR_W = 4
) (
  input  wire logic                         aclk,
  input  wire logic                         aresetn,
  input  wire logic [ADDR_W-1:0]            s_axi_awaddr,
  input  wire logic                         s_axi_awvalid,
  output logic                              s_axi_awready,
  input  wire logic [31:0]                  s_axi_wdata,
  input  wire logic [3:0]                   s_axi_wstrb,
  input  wire logic                         s_axi_wvalid,
  output logic                              s_axi_wready,
  output logic [1:0]                        s_axi_bresp,
  output logic                              s_axi_bvalid,
  input  wire logic                         s_axi_bready,
  input  wire logic [ADDR_W-1:0]            s_axi_araddr,
  input  wire logic                         s_axi_arvalid,
  output logic                              s_axi_arready,
  output logic [31:0]                       s_axi_rdata,
  output logic [1:0]                        s_axi_rresp,
  output logic                              s_axi_rvalid,
  input  wire logic                         s_axi_rready,
  input  wire sos_pkg::sos_clk_src_t        cpu_clk_src,
  input  wire logic                         halt_req,
  input  wire logic                         stop_req,
  input  wire logic                         irq_pending,
  input  wire logic                         main_osc_ok,
  input  wire logic                         main_tick,
  input  wire logic                         int_tick,
  output sos_pkg::sos_osc_ctl_t             osc_ctl
);

  // standby sequencer states
  typedef enum logic [2:0] {
    ST_RUN,       // cpu clocked
    ST_HALT,      // cpu gated, main crystal on
    ST_STOP,      // cpu gated, main crystal off
    ST_OSC_WAIT,  // main crystal restarting, not yet oscillating
    ST_SETTLE,    // counting main crystal stabilisation
    ST_RO_WAIT    // counting internal-oscillator periods
  } sos_state_t;

  sos_state_t                    state_r;       // sequencer state
  sos_state_t                    state_nxt;     // next state
  sos_pkg::sos_osc_ctl_t         osc_r;         // registered clock gates
  sos_pkg::sos_osc_ctl_t         osc_nxt;       // next clock gates
  logic                          refused_r;     // last stop was refused
  logic                          refused_nxt;   // next refused flag
  logic                          cnt_clr;       // restart stabilisation count
  logic                          ro_clr;        // restart period count
  logic [sos_pkg::CNT_W-1:0]     settle_cnt;    // stabilisation count
  logic [sos_pkg::RO_W-1:0]      ro_cnt;        // internal periods seen
  logic [sos_pkg::SETTLE_NB-1:0] settle_stat;   // settle_status_register
  logic                          settle_done;   // selected wait elapsed
  logic                          ro_done;       // seventeen periods elapsed

  // register file
  logic [sos_pkg::SEL_W-1:0]     sel_r;         // settle_select_register
  logic [sos_pkg::SEL_W-1:0]     sel_nxt;       // next select value
  logic                          int_off_r;     // software asks int osc off
  logic                          int_off_nxt;   // next int-off request

  // bus channel state
  logic                          aw_held_r;     // write address captured
  logic                          aw_held_nxt;
  logic                          w_held_r;      // write data captured
  logic                          w_held_nxt;
  logic [ADDR_W-1:0]             waddr_r;       // captured write address
  logic [ADDR_W-1:0]             waddr_nxt;
  logic [31:0]                   wdata_r;       // captured write data
  logic [31:0]                   wdata_nxt;
  logic                          wstrb0_r;      // low byte lane enabled
  logic                          wstrb0_nxt;
  logic                          awready_r;
  logic                          awready_nxt;
  logic                          wready_r;
  logic                          wready_nxt;
  logic                          bvalid_r;
  logic                          bvalid_nxt;
  logic [1:0]                    bresp_r;
  logic [1:0]                    bresp_nxt;
  logic                          arready_r;
  logic                          arready_nxt;
  logic                          rvalid_r;
  logic                          rvalid_nxt;
  logic [31:0]                   rdata_r;
  logic [31:0]                   rdata_nxt;
  logic [1:0]                    rresp_r;
  logic [1:0]                    rresp_nxt;
  logic                          wr_go;         // both halves of a write held
  logic [31:0]                   rd_word;       // decoded read value
  logic                          rd_hit;        // read address is mapped
  logic [5:0]                    state_word;    // live state bits

  // stabilisation counter only runs on real crystal ticks, so the
  // start-up gap before oscillation is never part of the wait
  sos_tick_counter #(
    .W       (sos_pkg::CNT_W)
  ) u_settle_cnt (
    .aclk    (aclk),
    .aresetn (aresetn),
    .clr     (cnt_clr),
    .inc     (osc_r.main_osc_en && main_osc_ok && main_tick && !settle_done),
    .q       (settle_cnt)
  );

  // counts internal-oscillator periods after stop release
  sos_tick_counter #(
    .W       (sos_pkg::RO_W)
  ) u_ro_cnt (
    .aclk    (aclk),
    .aresetn (aresetn),
    .clr     (ro_clr),
    .inc     ((state_r == ST_RO_WAIT) && int_tick),
    .q       (ro_cnt)
  );

  // settle status bits and selected-period compare
  sos_settle_status #(
    .NB      (sos_pkg::SETTLE_NB)
  ) u_settle_stat (
    .aclk    (aclk),
    .aresetn (aresetn),
    .clr     (cnt_clr),
    .count   (settle_cnt),
    .sel     (sel_r),
    .status  (settle_stat),
    .done    (settle_done)
  );

  assign ro_done = (ro_cnt >= sos_pkg::RO_WAIT);

  // standby sequencing and clock gating
  always_comb
  begin
    state_nxt   = state_r;
    refused_nxt = refused_r;
    cnt_clr     = 1'b0;
    ro_clr      = 1'b0;
    unique case (state_r)
      ST_RUN:
      begin
        if (stop_req)
        begin
          if (cpu_clk_src == sos_pkg::CLK_SUB)
            refused_nxt = 1'b1;
          else if (irq_pending)
          begin
            // an unmasked request turns stop into a halt with a full wait
            refused_nxt = 1'b0;
            cnt_clr     = 1'b1;
            state_nxt   = ST_SETTLE;
          end
          else
          begin
            refused_nxt = 1'b0;
            cnt_clr     = 1'b1;
            state_nxt   = ST_STOP;
          end
        end
        else if (halt_req)
          state_nxt = ST_HALT;
      end
      ST_HALT:
      begin
        if (irq_pending)
          state_nxt = ST_RUN;
      end
      ST_STOP:
      begin
        // release by interrupt; reset release enters via reset state
        if (irq_pending)
        begin
          ro_clr = 1'b1;
          if (cpu_clk_src == sos_pkg::CLK_INT)
            state_nxt = ST_RO_WAIT;
          else
            state_nxt = ST_OSC_WAIT;
        end
      end
      ST_OSC_WAIT:
      begin
        if (main_osc_ok)
          state_nxt = ST_SETTLE;
      end
      ST_SETTLE:
      begin
        if (settle_done)
          state_nxt = ST_RUN;
      end
      ST_RO_WAIT:
      begin
        // crystal keeps settling in the background; cpu needs only f_R
        if (ro_done)
          state_nxt = ST_RUN;
      end
    endcase

    // clock gates follow the next state so outputs leave flip-flops
    osc_nxt.cpu_clk_en  = (state_nxt == ST_RUN);
    osc_nxt.main_osc_en = (state_nxt != ST_STOP);
    // internal oscillator may only be switched off by software while
    // outside stop and while it is not the cpu clock; never inside stop
    if ((state_nxt == ST_STOP) || (state_r == ST_STOP))
      osc_nxt.int_osc_en = osc_r.int_osc_en;
    else if (int_off_r && (cpu_clk_src != sos_pkg::CLK_INT))
      osc_nxt.int_osc_en = 1'b0;
    else
      osc_nxt.int_osc_en = 1'b1;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_r   <= ST_OSC_WAIT;  // reset release also waits for the crystal
      osc_r     <= sos_pkg::OSC_RST;  // cpu stays gated until the wait ends
      refused_r <= 1'b0;
    end
    else
    begin
      state_r   <= state_nxt;
      osc_r     <= osc_nxt;
      refused_r <= refused_nxt;
    end
  end

  assign osc_ctl = osc_r;

  // live view of the sequencer for software
  always_comb
  begin
    state_word                        = '0;
    state_word[sos_pkg::STB_HALT]     = (state_r == ST_HALT) || (state_r == ST_SETTLE);
    state_word[sos_pkg::STB_STOP]     = (state_r == ST_STOP);
    state_word[sos_pkg::STB_WAIT]     = (state_r == ST_OSC_WAIT) ||
                                        (state_r == ST_SETTLE) ||
                                        (state_r == ST_RO_WAIT);
    state_word[sos_pkg::STB_REFUSED]  = refused_r;
    state_word[sos_pkg::STB_MAIN_EN]  = osc_r.main_osc_en;
    state_word[sos_pkg::STB_INT_EN]   = osc_r.int_osc_en;
  end

  // read decode; unmapped addresses answer slverr with zero data
  always_comb
  begin
    rd_word = '0;
    rd_hit  = 1'b1;
    unique case (s_axi_araddr)
      sos_pkg::OFS_STATUS: rd_word[sos_pkg::SETTLE_NB-1:0] = settle_stat;
      sos_pkg::OFS_SELECT: rd_word[sos_pkg::SEL_W-1:0]     = sel_r;
      sos_pkg::OFS_STATE:  rd_word[5:0]                    = state_word;
      sos_pkg::OFS_CTRL:   rd_word[sos_pkg::CTB_INT_OFF]   = int_off_r;
      default:             rd_hit                          = 1'b0;
    endcase
  end

  assign wr_go = aw_held_r && w_held_r && !bvalid_r;

  // bus slave: address and data taken in either order, one write and
  // one read outstanding; the response costs one cycle after both held
  always_comb
  begin
    aw_held_nxt = aw_held_r;
    w_held_nxt  = w_held_r;
    waddr_nxt   = waddr_r;
    wdata_nxt   = wdata_r;
    wstrb0_nxt  = wstrb0_r;
    bvalid_nxt  = bvalid_r;
    bresp_nxt   = bresp_r;
    sel_nxt     = sel_r;
    int_off_nxt = int_off_r;
    rvalid_nxt  = rvalid_r;
    rdata_nxt   = rdata_r;
    rresp_nxt   = rresp_r;
    if (s_axi_awvalid && awready_r)
    begin
      aw_held_nxt = 1'b1;
      waddr_nxt   = s_axi_awaddr;
    end
    if (s_axi_wvalid && wready_r)
    begin
      w_held_nxt = 1'b1;
      wdata_nxt  = s_axi_wdata;
      wstrb0_nxt = s_axi_wstrb[0];
    end
    if (bvalid_r && s_axi_bready)
      bvalid_nxt = 1'b0;
    if (wr_go)
    begin
      aw_held_nxt = 1'b0;
      w_held_nxt  = 1'b0;
      bvalid_nxt  = 1'b1;
      bresp_nxt   = sos_pkg::RESP_OKAY;
      unique case (waddr_r)
        sos_pkg::OFS_SELECT:
        begin
          if (wstrb0_r)
            sel_nxt = wdata_r[sos_pkg::SEL_W-1:0];
        end
        sos_pkg::OFS_CTRL:
        begin
          if (wstrb0_r)
            int_off_nxt = wdata_r[sos_pkg::CTB_INT_OFF];
        end
        sos_pkg::OFS_STATUS, sos_pkg::OFS_STATE:
          bresp_nxt = sos_pkg::RESP_OKAY;  // read-only, write ignored
        default:
          bresp_nxt = sos_pkg::RESP_SLVERR;
      endcase
    end
    if (rvalid_r && s_axi_rready)
      rvalid_nxt = 1'b0;
    if (s_axi_arvalid && arready_r)
    begin
      rvalid_nxt = 1'b1;
      rdata_nxt  = rd_word;
      rresp_nxt  = rd_hit ? sos_pkg::RESP_OKAY : sos_pkg::RESP_SLVERR;
    end
    // ready is withheld while a half is held or a reply is pending
    awready_nxt = !aw_held_nxt && !bvalid_nxt;
    wready_nxt  = !w_held_nxt && !bvalid_nxt;
    arready_nxt = !rvalid_nxt;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_r <= 1'b0;
      w_held_r  <= 1'b0;
      waddr_r   <= '0;
      wdata_r   <= '0;
      wstrb0_r  <= 1'b0;
      awready_r <= 1'b0;
      wready_r  <= 1'b0;
      bvalid_r  <= 1'b0;
      bresp_r   <= sos_pkg::RESP_OKAY;
      arready_r <= 1'b0;
      rvalid_r  <= 1'b0;
      rdata_r   <= '0;
      rresp_r   <= sos_pkg::RESP_OKAY;
      sel_r     <= sos_pkg::SEL_RST;
      int_off_r <= 1'b0;
    end
    else
    begin
      aw_held_r <= aw_held_nxt;
      w_held_r  <= w_held_nxt;
      waddr_r   <= waddr_nxt;
      wdata_r   <= wdata_nxt;
      wstrb0_r  <= wstrb0_nxt;
      awready_r <= awready_nxt;
      wready_r  <= wready_nxt;
      bvalid_r  <= bvalid_nxt;
      bresp_r   <= bresp_nxt;
      arready_r <= arready_nxt;
      rvalid_r  <= rvalid_nxt;
      rdata_r   <= rdata_nxt;
      rresp_r   <= rresp_nxt;
      sel_r     <= sel_nxt;
      int_off_r <= int_off_nxt;
    end
  end

  assign s_axi_awready = awready_r;
  assign s_axi_wready  = wready_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rdata   = rdata_r;
  assign s_axi_rresp   = rresp_r;

endmodule

// ---- src/sos_tick_counter.sv ----
// saturating up-counter with synchronous clear
`timescale 1ns/1ps
module sos_tick_counter #(
  parameter int W = 17
) (
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic         clr,
  input  wire logic         inc,
  output logic [W-1:0]      q
);

  logic [W-1:0] q_r;    // count value
  logic [W-1:0] q_nxt;  // next count

  // clear wins, then count until all ones
  always_comb
  begin
    q_nxt = q_r;
    if (clr)
      q_nxt = '0;
    else if (inc && (q_r != {W{1'b1}}))
      q_nxt = q_r + {{(W-1){1'b0}}, 1'b1};
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      q_r <= '0;
    else
      q_r <= q_nxt;
  end

  assign q = q_r;

endmodule
